// file: wco_pkg.sv
// Constants, register map and encodings of the weld current offset and PIN lockout block
//
// Function
// R1 - Offset code zero: any operate-mode weld current change is refused
// R2 - Single-schedule code N: current may move between base minus N and base plus N
// R3 - Code 25 selects all schedules, limit is code minus twenty, here five percent
// R4 - In kA mode the window is N percent of maximum RMS current
// R5 - Lock PIN accepted only from 0001 to 9999
// R6 - With a PIN stored, next program/operate release flashes lock and locks
// R7 - Locked: program mode only after correct PIN or lockout key switch
// R8 - Locked: PIN parameter reads back as zeros
// R9 - Press while locked: half-second PIN prompt and LED flash, then PIN parameter
// R10 - Matching PIN: on enter release flash unlock and go to program mode
// R11 - Wrong PIN: on enter release flash error pattern and stay locked
// R12 - Leaving program mode re-locks with the newest PIN, else the previous one
// R13 - Clear code 02 erases extended data including PIN, disabling lockout
// R14 - Program/operate held at power-up or estop reset clears PIN
// R15 - After reset PIN lockout is disabled
// R16 - Two-stage switch, first stage only: valve on, no sequencing
// R17 - No-weld selected: full timed sequence runs but weld current never fires
// R18 - Single stage: one pilot closure starts the sequence
// R19 - Codes 01-19 single schedule, 00 and 20 disabled, 21-39 all schedules
// R20 - Requests beyond the window are clamped to the nearest limit
// R21 - PIN matches only when all four entered digits equal the stored ones
package wco_pkg;
	localparam int CLK_HZ   = 10_000_000;
	localparam int FLASH_MS = 500;
	localparam int FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
	localparam int LINE_US  = 16667;
	localparam int LINE_CYC = LINE_US * (CLK_HZ / 1_000_000);

	localparam int ADDR_W = 6;
	localparam logic [5:0] A_CFG    = 6'h00;
	localparam logic [5:0] A_MAXRMS = 6'h04;
	localparam logic [5:0] A_SCHED  = 6'h08;
	localparam logic [5:0] A_BASE   = 6'h0C;
	localparam logic [5:0] A_OPCUR  = 6'h10;
	localparam logic [5:0] A_PIN    = 6'h14;
	localparam logic [5:0] A_ENTRY  = 6'h18;
	localparam logic [5:0] A_EXTCLR = 6'h1C;
	localparam logic [5:0] A_TIMES  = 6'h20;
	localparam logic [5:0] A_STATUS = 6'h24;

	localparam int CFG_KA_BIT     = 6;
	localparam int CFG_NOWELD_BIT = 7;
	localparam logic [7:0]  CFG_RST    = 8'h00;
	localparam logic [15:0] MAXRMS_RST = 16'h0000;
	localparam logic [31:0] TIMES_RST  = 32'h00000000;
	localparam logic [15:0] PIN_RST    = 16'h0000;

	localparam logic [5:0] OFS_SINGLE_MAX = 6'h13;
	localparam logic [5:0] OFS_ALL_BASE   = 6'h14;
	localparam logic [5:0] OFS_ALL_MAX    = 6'h27;
	localparam logic [21:0] PCT_DIV       = 22'h000064;
	localparam logic [7:0] EXTCLR_CODE    = 8'h02;
	localparam logic [3:0] BCD_MAX        = 4'h9;
	localparam int SCHED_W = 4;

	localparam int ST_PROG   = 0;
	localparam int ST_LOCKED = 1;
	localparam int ST_PINSET = 2;
	localparam int ST_PINVIEW = 3;
	localparam int ST_BUSY   = 4;
	localparam int ST_DISP   = 8;

	typedef enum logic [2:0] {DISP_NONE, DISP_LOCK, DISP_PROMPT, DISP_UNLOCK, DISP_ERROR} wco_disp_t;
	typedef enum logic [2:0] {SQ_IDLE, SQ_READY, SQ_SQZ, SQ_WELD, SQ_HOLD, SQ_OFF} wco_seq_t;
endpackage

// file: wco_mem.sv
// Schedule current store: base and operate current per schedule
`timescale 1ns/1ps
`default_nettype none
module wco_mem (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        we,
	input  wire logic [3:0]  addr,
	input  wire logic [31:0] wd,
	output logic      [31:0] rd
);
	logic [31:0] mem [16];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wd;
		end
	end

	// Registered read keeps the clamp path short
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd <= 32'h00000000;
		end else begin
			rd <= we ? wd : mem[addr];
		end
	end
endmodule
`default_nettype wire

// file: wco_top.sv
// Weld current offset limiter, PIN lockout and pilot initiation sequencer
`timescale 1ns/1ps
`default_nettype none
module wco_top #(
	parameter int FLASH_CYCLES = wco_pkg::FLASH_CYC,
	parameter int TICK_CYCLES  = wco_pkg::LINE_CYC
) (
	input  wire logic                      CLK,
	input  wire logic                      RST,
	input  wire logic [wco_pkg::ADDR_W-1:0] AVS_ADDRESS,
	input  wire logic                      AVS_READ,
	input  wire logic                      AVS_WRITE,
	input  wire logic [31:0]               AVS_WRITEDATA,
	output logic      [31:0]               AVS_READDATA,
	output logic                           AVS_WAITREQUEST,
	input  wire logic                      PROG_OP_BTN,
	input  wire logic                      ENTER_BTN,
	input  wire logic                      LOCKOUT_KEY,
	input  wire logic                      ESTOP_RESET,
	input  wire logic                      PILOT_STAGE1,
	input  wire logic                      PILOT_STAGE2,
	input  wire logic                      TWO_STAGE,
	input  wire logic                      NO_WELD_INPUT,
	output logic                           PROGRAM_MODE,
	output logic                           LOCKED,
	output logic      [2:0]                DISP_CODE,
	output logic                           PROG_LED_FLASH,
	output logic                           VALVE,
	output logic                           WELD_FIRE,
	output logic                           SEQ_BUSY
);
	import wco_pkg::*;

	logic [1:0]  ph_r;
	logic        wait_r;
	logic [31:0] rdata_r;
	logic [7:0]  cfg_r;
	logic [15:0] maxrms_r;
	logic [3:0]  sched_r;
	logic [31:0] times_r;
	logic [15:0] pin_r;
	logic [15:0] entry_r;
	logic signed [16:0] gdelta_r;
	logic        pin_set_r;
	logic        locked_r;
	logic        prog_r;
	logic        pin_view_r;
	logic        boot_r;
	logic        prog_q_r;
	logic        ent_q_r;
	logic [22:0] flash_cnt_r;
	wco_disp_t   disp_r;
	logic        led_r;
	logic [31:0] mem_rd;
	logic        mem_we;
	logic [31:0] mem_wd;
	logic [3:0]  dig_ok;
	logic [3:0]  dig_eq;

	////////////////////////////////////////////////////////////////////////////
	// Avalon slave: request seen, memory read, answer in the third cycle

	wire        req     = AVS_READ | AVS_WRITE;
	wire        wr_take = AVS_WRITE & ~wait_r;
	wire [15:0] wd16    = AVS_WRITEDATA[15:0];
	wire wr_cfg    = wr_take & (AVS_ADDRESS == A_CFG) & prog_r;
	wire wr_maxrms = wr_take & (AVS_ADDRESS == A_MAXRMS) & prog_r;
	wire wr_sched  = wr_take & (AVS_ADDRESS == A_SCHED);
	wire wr_base   = wr_take & (AVS_ADDRESS == A_BASE) & prog_r;
	wire wr_opcur  = wr_take & (AVS_ADDRESS == A_OPCUR) & ~prog_r;
	wire wr_pin    = wr_take & (AVS_ADDRESS == A_PIN) & prog_r;
	wire wr_entry  = wr_take & (AVS_ADDRESS == A_ENTRY);
	wire wr_clr    = wr_take & (AVS_ADDRESS == A_EXTCLR) & (AVS_WRITEDATA[7:0] == EXTCLR_CODE); // R13
	wire wr_times  = wr_take & (AVS_ADDRESS == A_TIMES) & prog_r;
	wire [1:0] ph_nxt = (ph_r == 2'h2 || !req) ? 2'h0 : ph_r + 2'h1;

	////////////////////////////////////////////////////////////////////////////
	// Offset window

	wire [5:0]  code    = cfg_r[5:0];
	wire        single  = (code != 6'h00) && (code <= OFS_SINGLE_MAX);               // R19
	wire        all_sch = (code > OFS_ALL_BASE) && (code <= OFS_ALL_MAX);            // R19
	wire [5:0]  n_pct   = single ? code : (all_sch ? code - OFS_ALL_BASE : 6'h00);   // R3
	wire [21:0] ka_prod = maxrms_r * n_pct;
	wire [21:0] ka_win  = ka_prod / PCT_DIV;                                          // R4
	wire [15:0] halfw   = cfg_r[CFG_KA_BIT] ? ka_win[15:0] : {10'h000, n_pct};        // R2
	wire [15:0] base    = mem_rd[15:0];
	wire [15:0] lo      = (base > halfw) ? base - halfw : 16'h0000;
	wire [16:0] hi17    = {1'b0, base} + {1'b0, halfw};
	wire [15:0] hi      = hi17[16] ? 16'hFFFF : hi17[15:0];
	wire [15:0] clamped = (wd16 < lo) ? lo : ((wd16 > hi) ? hi : wd16);              // R20
	wire [16:0] delta   = {1'b0, clamped} - {1'b0, base};
	wire [15:0] oper_all = base + gdelta_r[15:0];
	wire [15:0] oper_cur = all_sch ? oper_all : (single ? mem_rd[31:16] : base);

	assign mem_we = wr_base | (wr_opcur & single);                                    // R1
	assign mem_wd = wr_base ? {wd16, wd16} : {clamped, base};

	wco_mem u_mem (
		.clk  (CLK),
		.rst  (RST),
		.we   (mem_we),
		.addr (sched_r),
		.wd   (mem_wd),
		.rd   (mem_rd)
	);

	////////////////////////////////////////////////////////////////////////////
	// PIN checks, one lane per BCD digit

	for (genvar g = 0; g < 4; g++) begin : g_dig
		assign dig_ok[g] = AVS_WRITEDATA[4*g +: 4] <= BCD_MAX;                        // R5
		assign dig_eq[g] = entry_r[4*g +: 4] == pin_r[4*g +: 4];                      // R21
	end
	wire pin_fmt_ok = (&dig_ok) && (wd16 != 16'h0000) && (AVS_WRITEDATA[31:16] == 16'h0000);
	wire pin_match  = &dig_eq;

	wire [31:0] status = {16'h0000, 5'h00, disp_r, 3'h0, SEQ_BUSY, pin_view_r, pin_set_r, locked_r, prog_r};
	wire [15:0] pin_rd = locked_r ? 16'h0000 : pin_r;                                 // R8
	wire [31:0] rd_mux =
		(AVS_ADDRESS == A_CFG)    ? {24'h000000, cfg_r} :
		(AVS_ADDRESS == A_MAXRMS) ? {16'h0000, maxrms_r} :
		(AVS_ADDRESS == A_SCHED)  ? {28'h0000000, sched_r} :
		(AVS_ADDRESS == A_BASE)   ? {16'h0000, base} :
		(AVS_ADDRESS == A_OPCUR)  ? {16'h0000, oper_cur} :
		(AVS_ADDRESS == A_PIN)    ? {16'h0000, pin_rd} :
		(AVS_ADDRESS == A_TIMES)  ? times_r :
		(AVS_ADDRESS == A_STATUS) ? status : 32'h00000000;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ph_r    <= 2'h0;
			wait_r  <= 1'b1;
			rdata_r <= 32'h00000000;
		end else begin
			ph_r    <= ph_nxt;
			wait_r  <= ~(ph_r == 2'h1 && req);
			rdata_r <= (ph_r == 2'h1 && AVS_READ) ? rd_mux : rdata_r;
		end
	end
	assign AVS_WAITREQUEST = wait_r;
	assign AVS_READDATA    = rdata_r;

	////////////////////////////////////////////////////////////////////////////
	// Configuration registers

	// Clear code resets the config byte, offset code included, and the all-schedule delta; max RMS and times are kept
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cfg_r    <= CFG_RST;
			maxrms_r <= MAXRMS_RST;
			sched_r  <= 4'h0;
			times_r  <= TIMES_RST;
			entry_r  <= 16'h0000;
			gdelta_r <= 17'h00000;
		end else begin
			cfg_r    <= wr_clr ? CFG_RST : (wr_cfg ? AVS_WRITEDATA[7:0] : cfg_r);   // R13
			maxrms_r <= wr_maxrms ? wd16 : maxrms_r;
			sched_r  <= wr_sched ? AVS_WRITEDATA[SCHED_W-1:0] : sched_r;
			times_r  <= wr_times ? AVS_WRITEDATA : times_r;
			entry_r  <= wr_entry ? wd16 : entry_r;
			gdelta_r <= (wr_clr || wr_cfg) ? 17'h00000 :
				((wr_opcur && all_sch) ? delta : gdelta_r);                          // R3
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Lockout state

	wire prog_press = PROG_OP_BTN & ~prog_q_r;
	wire prog_rel   = ~PROG_OP_BTN & prog_q_r;
	wire ent_rel    = ~ENTER_BTN & ent_q_r;
	// Button level is caught by a clocked stage while held, never by the reset
	wire held_clr   = PROG_OP_BTN & (~boot_r | ESTOP_RESET);                           // R14
	wire clr_all    = wr_clr | held_clr;
	wire flash_end  = (disp_r != DISP_NONE) && (flash_cnt_r == 23'h000000);
	wire try_pin    = ent_rel & locked_r & pin_view_r;
	wire leave_prog = prog_rel & prog_r;
	wire key_unlock = prog_rel & locked_r & LOCKOUT_KEY;                                // R7
	wire do_lock    = leave_prog & pin_set_r;                                           // R6
	wire do_unlock  = (try_pin & pin_match) | key_unlock;                               // R10
	wire bad_pin    = try_pin & ~pin_match;                                             // R11
	wire prompt     = prog_press & locked_r & ~LOCKOUT_KEY;                             // R9
	wire enter_prog = (prog_rel & ~prog_r & ~locked_r) | do_unlock;
	wire start_fl   = do_lock | do_unlock | bad_pin | prompt;
	wire [22:0] fl_load = 23'(FLASH_CYCLES - 1);
	wco_disp_t fl_code;
	assign fl_code = do_lock ? DISP_LOCK : (do_unlock ? DISP_UNLOCK : (bad_pin ? DISP_ERROR : DISP_PROMPT));

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			boot_r    <= 1'b0;
			prog_q_r  <= 1'b0;
			ent_q_r   <= 1'b0;
			pin_r     <= PIN_RST;                                                      // R15
			pin_set_r <= 1'b0;                                                         // R15
			locked_r  <= 1'b0;
			prog_r    <= 1'b0;
		end else begin
			boot_r    <= 1'b1;
			prog_q_r  <= PROG_OP_BTN;
			ent_q_r   <= ENTER_BTN;
			pin_r     <= clr_all ? PIN_RST : ((wr_pin && pin_fmt_ok) ? wd16 : pin_r);   // R12
			pin_set_r <= clr_all ? 1'b0 : ((wr_pin && pin_fmt_ok) ? 1'b1 : pin_set_r);
			locked_r  <= clr_all ? 1'b0 : (do_lock ? 1'b1 : (do_unlock ? 1'b0 : locked_r));
			prog_r    <= enter_prog ? 1'b1 : (leave_prog ? 1'b0 : prog_r);
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			flash_cnt_r <= 23'h000000;
			disp_r      <= DISP_NONE;
			led_r       <= 1'b0;
			pin_view_r  <= 1'b0;
		end else if (start_fl) begin
			flash_cnt_r <= fl_load;
			disp_r      <= fl_code;
			led_r       <= prompt;                                                     // R9
			pin_view_r  <= pin_view_r & ~do_unlock & ~clr_all;
		end else begin
			flash_cnt_r <= (flash_cnt_r != 23'h000000) ? flash_cnt_r - 23'h000001 : flash_cnt_r;
			disp_r      <= flash_end ? DISP_NONE : disp_r;
			led_r       <= flash_end ? 1'b0 : led_r;
			pin_view_r  <= ((flash_end && disp_r == DISP_PROMPT) | pin_view_r) & ~clr_all & locked_r; // R9
		end
	end
	assign PROGRAM_MODE   = prog_r;
	assign LOCKED         = locked_r;
	assign DISP_CODE      = disp_r;
	assign PROG_LED_FLASH = led_r;

	////////////////////////////////////////////////////////////////////////////
	// Pilot initiation and timed sequence, counted in line cycles

	logic [17:0] tick_cnt_r;
	logic [7:0]  tcnt_r;
	logic        start_q_r;
	logic        valve_r;
	logic        weld_r;
	logic        busy_r;
	wco_seq_t    seq_r;
	wco_seq_t    seq_nxt;
	wire tick  = (tick_cnt_r == 18'h00000);
	wire start = TWO_STAGE ? (PILOT_STAGE1 & PILOT_STAGE2) : PILOT_STAGE1;             // R18
	wire start_rise = start & ~start_q_r;
	wire t_done = tick & (tcnt_r == 8'h00);
	wire no_weld = NO_WELD_INPUT | cfg_r[CFG_NOWELD_BIT];

	always_comb begin
		seq_nxt = seq_r;
		unique case (seq_r)
			SQ_IDLE: begin
				if (start_rise) begin
					seq_nxt = SQ_SQZ;
				end else if (TWO_STAGE && PILOT_STAGE1) begin
					seq_nxt = SQ_READY;                                                // R16
				end
			end
			SQ_READY: begin
				// Fresh closure only, so a switch still held after a sequence cannot restart it
				if (start_rise) begin
					seq_nxt = SQ_SQZ;
				end else if (!PILOT_STAGE1) begin
					seq_nxt = SQ_IDLE;
				end
			end
			SQ_SQZ:  seq_nxt = t_done ? SQ_WELD : seq_r;
			SQ_WELD: seq_nxt = t_done ? SQ_HOLD : seq_r;
			SQ_HOLD: seq_nxt = t_done ? SQ_OFF : seq_r;
			SQ_OFF:  seq_nxt = t_done ? SQ_IDLE : seq_r;
		endcase
	end

	wire [7:0] t_load = (seq_nxt == SQ_SQZ) ? times_r[7:0] : ((seq_nxt == SQ_WELD) ? times_r[15:8] :
		((seq_nxt == SQ_HOLD) ? times_r[23:16] : times_r[31:24]));

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			tick_cnt_r <= 18'h00000;
			tcnt_r     <= 8'h00;
			start_q_r  <= 1'b0;
			seq_r      <= SQ_IDLE;
			valve_r    <= 1'b0;
			weld_r     <= 1'b0;
			busy_r     <= 1'b0;
		end else begin
			tick_cnt_r <= tick ? 18'(TICK_CYCLES - 1) : tick_cnt_r - 18'h00001;
			tcnt_r     <= (seq_nxt != seq_r) ? t_load : (tick ? tcnt_r - 8'h01 : tcnt_r);
			start_q_r  <= start;
			seq_r      <= seq_nxt;
			valve_r    <= (seq_nxt != SQ_IDLE) && (seq_nxt != SQ_OFF);
			weld_r     <= (seq_nxt == SQ_WELD) && !no_weld;                            // R17
			busy_r     <= (seq_nxt != SQ_IDLE) && (seq_nxt != SQ_READY);
		end
	end
	assign VALVE     = valve_r;
	assign WELD_FIRE = weld_r;
	assign SEQ_BUSY  = busy_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	bus_answer_a: assert property (@(posedge CLK) disable iff (RST) // bus answer timing
		req && ph_r == 2'h0 |-> wait_r ##1 wait_r ##1 !wait_r)
		else $error("bus answer not in third cycle");
	offset_off_a: assert property (@(posedge CLK) disable iff (RST) // R1
		wr_opcur && !single && !all_sch |=> $stable(gdelta_r) && $stable(mem_rd))
		else $error("current changed with offset disabled");
	clamp_win_a: assert property (@(posedge CLK) disable iff (RST) // R20
		wr_opcur && single |-> mem_wd[31:16] >= lo && mem_wd[31:16] <= hi)
		else $error("operate current outside window");
	all_limit_a: assert property (@(posedge CLK) disable iff (RST) // R3
		code == 6'h19 |-> all_sch && n_pct == 6'h05)
		else $error("code 25 limit wrong");
	pin_range_a: assert property (@(posedge CLK) disable iff (RST) // R5
		pin_set_r && $changed(pin_r) |-> $past(wr_pin) && $past(pin_fmt_ok))
		else $error("PIN stored out of range");
	lock_rel_a: assert property (@(posedge CLK) disable iff (RST) // R6
		do_lock && !clr_all |=> locked_r && !prog_r && disp_r == DISP_LOCK)
		else $error("lock not taken on release");
	locked_out_a: assert property (@(posedge CLK) disable iff (RST) // R7
		locked_r |-> !prog_r)
		else $error("program mode while locked");
	pin_hide_a: assert property (@(posedge CLK) disable iff (RST) // R8
		ph_r == 2'h1 && AVS_READ && AVS_ADDRESS == A_PIN && locked_r |=> rdata_r == 32'h00000000)
		else $error("PIN visible while locked");
	bad_pin_a: assert property (@(posedge CLK) disable iff (RST) // R11
		bad_pin && !clr_all |=> locked_r && disp_r == DISP_ERROR ##1 locked_r)
		else $error("wrong PIN unlocked");
	no_weld_a: assert property (@(posedge CLK) disable iff (RST) // R17
		NO_WELD_INPUT |=> !weld_r)
		else $error("weld fired in no weld");
	stage1_a: assert property (@(posedge CLK) disable iff (RST) // R16
		seq_r == SQ_READY |-> valve_r && !weld_r && !SEQ_BUSY)
		else $error("first stage sequenced");
endmodule
`default_nettype wire

// file: wco_panel.sv
// Operator panel model: push-buttons, key switch, estop reset and pilot switches
`timescale 1ns/1ps
`default_nettype none
module wco_panel (
	input  wire logic clk,
	output logic      prog_btn,
	output logic      enter_btn,
	output logic      key_sw,
	output logic      estop,
	output logic      stage1,
	output logic      stage2,
	output logic      two_stage,
	output logic      no_weld
);
	initial begin
		{prog_btn, enter_btn, key_sw, estop, stage1, stage2, two_stage, no_weld} = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////
	// Levels move only just after an edge, as a debounced panel would
	task automatic hold(input int sel, input logic lvl);
		@(posedge clk);
		case (sel)
			0: prog_btn <= lvl;
			1: enter_btn <= lvl;
			2: stage1 <= lvl;
			default: stage2 <= lvl;
		endcase
	endtask

	task automatic click(input int sel);
		hold(sel, 1'b1);
		repeat (3) @(posedge clk);
		hold(sel, 1'b0);
		repeat (3) @(posedge clk);
	endtask

	task automatic setup(input logic key, input logic two, input logic nw);
		@(posedge clk);
		key_sw <= key;
		two_stage <= two;
		no_weld <= nw;
	endtask

	task automatic pulse_estop();
		@(posedge clk);
		estop <= 1'b1;
		@(posedge clk);
		estop <= 1'b0;
	endtask
endmodule
`default_nettype wire

// file: wco_tb.sv
// Self-checking bench: offset window, PIN lockout and pilot sequencing
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import wco_pkg::*;
	localparam int FLASH = 20;
	localparam int CODES[8] = '{0, 5, 19, 20, 25, 39, 21, 5};
	localparam logic [31:0] PINS[6] = '{32'h9999, 32'h0000, 32'h1A34, 32'h10001, 32'h0001, 32'h1234};
	logic        clk, rst, rd, wr, wait_req, prog_btn, enter_btn, key_sw, estop;
	logic        stage1, stage2, two_stage, no_weld, prog_mode, locked, led, valve, fire, busy;
	logic [5:0]  addr;
	logic [31:0] wdata, rdat, rdata, seed, pin;
	logic [2:0]  disp;
	int          num_errors, checks;

	wco_panel panel (.clk(clk), .prog_btn(prog_btn), .enter_btn(enter_btn), .key_sw(key_sw), .estop(estop),
		.stage1(stage1), .stage2(stage2), .two_stage(two_stage), .no_weld(no_weld));
	wco_top #(.FLASH_CYCLES(FLASH), .TICK_CYCLES(4)) DUT (.CLK(clk), .RST(rst), .AVS_ADDRESS(addr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_req),
		.PROG_OP_BTN(prog_btn), .ENTER_BTN(enter_btn), .LOCKOUT_KEY(key_sw), .ESTOP_RESET(estop),
		.PILOT_STAGE1(stage1), .PILOT_STAGE2(stage2), .TWO_STAGE(two_stage), .NO_WELD_INPUT(no_weld),
		.PROGRAM_MODE(prog_mode), .LOCKED(locked), .DISP_CODE(disp), .PROG_LED_FLASH(led), .VALVE(valve),
		.WELD_FIRE(fire), .SEQ_BUSY(busy));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [31:0] exp_cur(input int code, input bit ka, input int base, input int req);
		int lim;
		if (code == 0 || code == 20)
			return base;
		lim = (code < 20) ? code : code - 20;
		// Window scales with max RMS, not with the base
		if (ka)
			lim = 2000 * lim / 100;
		if (req > base + lim)
			return base + lim;
		if (req < base - lim)
			return base - lim;
		return req;
	endfunction

	function automatic bit pin_ok(input logic [31:0] v);
		return v[31:16] == 16'h0000 && v != 32'h0 && v[3:0] <= 4'h9 && v[7:4] <= 4'h9 && v[11:8] <= 4'h9
			&& v[15:12] <= 4'h9;
	endfunction

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (wait_req !== 1'b0 && n < 50);
		rdata = rdat;
		if (n >= 50) begin
			num_errors++;
			$display("BAD bus answer expected 0 seen %b", wait_req);
		end
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic rdchk(input logic [5:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0);
		chk(what, exp, rdata);
	endtask

	task automatic mode(input logic want);
		if (prog_mode !== want)
			panel.click(0);
		chk("program mode", {31'h0, want}, {31'h0, prog_mode});
	endtask

	task automatic try_pin(input logic [31:0] v);
		panel.hold(0, 1'b1);
		repeat (3) @(posedge clk);
		chk("prompt", 32'h2, {29'h0, disp});
		chk("prog led", 32'h1, {31'h0, led});
		panel.hold(0, 1'b0);
		repeat (FLASH + 2) @(posedge clk);
		chk("still operate", 32'h0, {31'h0, prog_mode});
		rdchk(A_STATUS, 32'hE, "pin view");
		bus(1'b1, A_ENTRY, v);
		panel.click(1);
	endtask

	task automatic run_seq(input logic two, input logic nw);
		int n;
		bit fired;
		fired = 0;
		panel.setup(1'b0, two, nw);
		panel.hold(2, 1'b1);
		if (two) begin
			repeat (10) @(posedge clk);
			chk("stage one valve", 32'h1, {31'h0, valve});
			chk("stage one idle", 32'h0, {31'h0, busy});
			panel.hold(3, 1'b1);
		end
		repeat (2) @(posedge clk);
		chk("seq started", 32'h1, {31'h0, busy});
		for (n = 0; n < 300 && busy === 1'b1; n++) begin
			@(posedge clk);
			fired |= (fire === 1'b1);
		end
		chk("weld fired", {31'h0, !nw}, {31'h0, fired});
		chk("seq ended", 32'h0, {31'h0, busy});
		panel.hold(2, 1'b0);
		panel.hold(3, 1'b0);
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		$display("BAD watchdog expected done seen hang");
		final_report();
	end

	initial begin
		int i, j, base, req;
		bit ka;
		{num_errors, checks, rd, wr, addr, wdata, pin} = '0;
		seed = 32'h59;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdchk(A_STATUS, 32'h0, "status after reset");
		bus(1'b1, 6'h3C, 32'hFFFFFFFF);
		rdchk(6'h3C, 32'h0, "unmapped");
		$display("test reset done");
		for (i = 0; i < 8; i++) begin
			ka = (i == 7);
			mode(1'b1);
			bus(1'b1, A_CFG, {25'h0, ka, 6'(CODES[i])});
			bus(1'b1, A_MAXRMS, 32'h7D0);
			base = ka ? 1400 : 40 + int'(rnd() % 32'h28);
			bus(1'b1, A_BASE, 32'(base));
			mode(1'b0);
			for (j = 0; j < 4; j++) begin
				req = (j == 0) ? base + 200 : ka ? base - 150 + int'(rnd() % 32'h12C) : base - 30 + int'(rnd() % 32'h3C);
				bus(1'b1, A_OPCUR, 32'(req));
				rdchk(A_OPCUR, exp_cur(CODES[i], ka, base, req), "operate current");
			end
		end
		$display("test offset done");
		mode(1'b1);
		for (i = 0; i < 6; i++) begin
			bus(1'b1, A_PIN, PINS[i]);
			if (pin_ok(PINS[i]))
				pin = PINS[i];
			rdchk(A_PIN, pin, "pin store");
		end
		mode(1'b0);
		chk("lock", 32'h1, {31'h0, locked});
		chk("lock flash", 32'h1, {29'h0, disp});
		rdchk(A_PIN, 32'h0, "hidden pin");
		repeat (FLASH) @(posedge clk);
		try_pin(32'h1235);
		chk("error flash", 32'h4, {29'h0, disp});
		chk("stays locked", 32'h1, {31'h0, locked});
		repeat (FLASH) @(posedge clk);
		try_pin(32'h1234);
		chk("unlock flash", 32'h3, {29'h0, disp});
		chk("unlocked", 32'h1, {31'h0, prog_mode});
		mode(1'b0);
		chk("relock old", 32'h1, {31'h0, locked});
		panel.setup(1'b1, 1'b0, 1'b0);
		panel.click(0);
		chk("key unlock", 32'h1, {31'h0, prog_mode});
		panel.setup(1'b0, 1'b0, 1'b0);
		bus(1'b1, A_PIN, 32'h4321);
		mode(1'b0);
		repeat (FLASH) @(posedge clk);
		try_pin(32'h1234);
		chk("old pin refused", 32'h4, {29'h0, disp});
		repeat (FLASH) @(posedge clk);
		try_pin(32'h4321);
		chk("new pin", 32'h1, {31'h0, prog_mode});
		bus(1'b1, A_EXTCLR, {24'h0, EXTCLR_CODE});
		rdchk(A_PIN, 32'h0, "cleared pin");
		mode(1'b0);
		chk("clear unlocks", 32'h0, {31'h0, locked});
		mode(1'b1);
		bus(1'b1, A_PIN, 32'h5678);
		mode(1'b0);
		panel.hold(0, 1'b1);
		panel.pulse_estop();
		panel.hold(0, 1'b0);
		repeat (FLASH + 5) @(posedge clk);
		chk("estop clear", 32'h0, {31'h0, locked});
		// Release after the clear finds the block unlocked, so it enters program mode
		rdchk(A_STATUS, 32'h1, "no pin set");
		$display("test lockout done");
		mode(1'b1);
		bus(1'b1, A_TIMES, 32'h01020302);
		mode(1'b0);
		run_seq(1'b0, 1'b0);
		run_seq(1'b0, 1'b1);
		run_seq(1'b1, 1'b0);
		$display("test pilot done");
		final_report();
	end
endmodule
`default_nettype wire
